/* File: core/rtc_calendar.sv */
`include "rtc_cfg.svh"
module rtc_calendar #(
  parameter int PULSE_CYC = `RTC_ALARM_PULSE_CYC,
  parameter int OSC_HZ = `RTC_OSC_HZ
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic sys_rst,
  // Crystal pins and supply state.
  input wire logic osc_in,
  output logic osc_out,
  input wire logic on_backup,
  // Serial port.
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Open-drain outputs, pin low while the enable is high.
  output logic irq_o,
  output logic irq_oe,
  output logic freq_out_pin_o,
  output logic freq_out_pin_oe,
  // Status seen by the local system.
  output logic low_power_select,
  output logic alarm_flag
);
  localparam logic [6:0] DEV_ADDR = `RTC_I2C_ADDR;

  function automatic logic [7:0] days_in(input logic [7:0] m, input logic [7:0] y);
    case (m)
      8'h02: days_in = (y[1:0] == 2'h0) ? 8'h1D : 8'h1C;
      8'h04, 8'h06, 8'h09, 8'h0B: days_in = 8'h1E;
      default: days_in = 8'h1F;
    endcase
  endfunction : days_in

  function automatic logic field_ok(input logic [7:0] a, input logic [7:0] t);
    field_ok = !a[`RTC_ALM_EN] || (a[6:0] == t[6:0]);
  endfunction : field_ok

  // Pin synchronisers: first stage feeds only the second.
  logic [2:0] osc_sy, scl_sy, sda_sy;
  logic [1:0] bak_sy;
  always_ff @(posedge clock) begin
    osc_sy <= {osc_sy[1:0], osc_in};
    scl_sy <= {scl_sy[1:0], scl_i};
    sda_sy <= {sda_sy[1:0], sda_i};
    bak_sy <= {bak_sy[0], on_backup};
  end
  wire osc_tick = osc_sy[1] && !osc_sy[2];
  wire scl_rise = scl_sy[1] && !scl_sy[2];
  wire scl_fall = !scl_sy[1] && scl_sy[2];
  wire start_c = scl_sy[1] && scl_sy[2] && sda_sy[2] && !sda_sy[1];
  wire stop_c = scl_sy[1] && scl_sy[2] && !sda_sy[2] && sda_sy[1];
  wire backup = bak_sy[1];

  // Link state.
  rtc_pkg::link_state_e st_reg, st_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] sh_reg, sh_next, out_reg, out_next, ptr_reg, ptr_next;
  logic first_reg, first_next, sda_oe_reg, sda_oe_next, nack_reg, nack_next;
  logic wr_reg, wr_next, rd_st_reg, rd_st_next;
  logic [7:0] wa_reg, wa_next, wd_reg, wd_next;
  rtc_pkg::time_s snap_reg, snap_next;

  // Clock state.
  rtc_pkg::time_s tm_reg, tm_next;
  rtc_pkg::alarm_s al_reg, al_next;
  logic [14:0] pre_reg, pre_next;
  logic [7:0] ctrl_reg, ctrl_next;
  logic [3:0] frq_reg, frq_next;
  logic run_reg, run_next, flag_reg, flag_next, match_reg, match_next;
  logic [31:0] pcnt_reg, pcnt_next;
  logic irq_oe_reg, irq_oe_next, fo_oe_reg, fo_oe_next;

  function automatic logic [7:0] reg_read(input logic [7:0] a);
    case (a[3:0])
      `RTC_IDX_SEC: reg_read = snap_reg.sec;
      `RTC_IDX_MIN: reg_read = snap_reg.min;
      `RTC_IDX_HOUR: reg_read = snap_reg.hour;
      `RTC_IDX_DATE: reg_read = snap_reg.date;
      `RTC_IDX_MONTH: reg_read = snap_reg.month;
      `RTC_IDX_YEAR: reg_read = snap_reg.year;
      `RTC_IDX_DOW: reg_read = snap_reg.dow;
      `RTC_IDX_STATUS: reg_read = {6'h00, !run_reg, flag_reg};
      `RTC_IDX_CTRL: reg_read = ctrl_reg;
      `RTC_IDX_FREQ: reg_read = {4'h0, frq_reg};
      4'hA: reg_read = al_reg.sec;
      4'hB: reg_read = al_reg.min;
      4'hC: reg_read = al_reg.hour;
      4'hD: reg_read = al_reg.date;
      4'hE: reg_read = al_reg.month;
      default: reg_read = al_reg.dow;
    endcase
  endfunction : reg_read

  always_comb begin
    st_next = st_reg;
    bit_next = bit_reg;
    sh_next = sh_reg;
    out_next = out_reg;
    ptr_next = ptr_reg;
    first_next = first_reg;
    sda_oe_next = sda_oe_reg;
    nack_next = nack_reg;
    wr_next = 1'b0;
    rd_st_next = 1'b0;
    wa_next = wa_reg;
    wd_next = wd_reg;
    snap_next = snap_reg;
    if (backup || stop_c) begin
      st_next = rtc_pkg::LK_IDLE;
      sda_oe_next = 1'b0;
    end else if (start_c) begin
      st_next = rtc_pkg::LK_ADDR;
      bit_next = 4'h0;
      sda_oe_next = 1'b0;
      snap_next = tm_reg;
    end else if (scl_rise && st_reg != rtc_pkg::LK_IDLE) begin
      sh_next = {sh_reg[6:0], sda_sy[1]};
      bit_next = bit_reg + 4'h1;
      nack_next = sda_sy[1];
    end else if (scl_fall) begin
      case (st_reg)
        rtc_pkg::LK_ADDR: begin
          if (bit_reg == 4'h8) begin
            if (sh_reg[7:1] == DEV_ADDR) begin
              st_next = rtc_pkg::LK_ACK_A;
              sda_oe_next = 1'b1;
            end else begin
              st_next = rtc_pkg::LK_IDLE;
            end
          end
        end
        rtc_pkg::LK_ACK_A: begin
          bit_next = 4'h0;
          // The acknowledge clock has already shifted one more bit in behind the read flag.
          if (sh_reg[1]) begin
            st_next = rtc_pkg::LK_RD;
            out_next = reg_read(ptr_reg);
            rd_st_next = (ptr_reg[3:0] == `RTC_IDX_STATUS);
            sda_oe_next = !out_next[7];
          end else begin
            st_next = rtc_pkg::LK_WR;
            first_next = 1'b1;
            sda_oe_next = 1'b0;
          end
        end
        rtc_pkg::LK_WR: begin
          if (bit_reg == 4'h8) begin
            st_next = rtc_pkg::LK_ACK_W;
            sda_oe_next = 1'b1;
            first_next = 1'b0;
            if (first_reg) begin
              ptr_next = {4'h0, sh_reg[3:0]};
            end else begin
              wr_next = 1'b1;
              wa_next = ptr_reg;
              wd_next = sh_reg;
              ptr_next = {4'h0, ptr_reg[3:0] + 4'h1};
            end
          end
        end
        rtc_pkg::LK_ACK_W: begin
          st_next = rtc_pkg::LK_WR;
          bit_next = 4'h0;
          sda_oe_next = 1'b0;
        end
        rtc_pkg::LK_RD: begin
          if (bit_reg == 4'h8) begin
            st_next = rtc_pkg::LK_ACK_R;
            sda_oe_next = 1'b0;
          end else begin
            out_next = {out_reg[6:0], 1'b0};
            sda_oe_next = !out_reg[6];
          end
        end
        rtc_pkg::LK_ACK_R: begin
          bit_next = 4'h0;
          if (nack_reg) begin
            st_next = rtc_pkg::LK_IDLE;
          end else begin
            st_next = rtc_pkg::LK_RD;
            ptr_next = {4'h0, ptr_reg[3:0] + 4'h1};
            out_next = reg_read(ptr_next);
            rd_st_next = (ptr_next[3:0] == `RTC_IDX_STATUS);
            sda_oe_next = !out_next[7];
          end
        end
        default: st_next = rtc_pkg::LK_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_reg <= rtc_pkg::LK_IDLE;
      bit_reg <= 4'h0;
      sh_reg <= 8'h00;
      out_reg <= 8'h00;
      ptr_reg <= 8'h00;
      first_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      nack_reg <= 1'b0;
      wr_reg <= 1'b0;
      rd_st_reg <= 1'b0;
      wa_reg <= 8'h00;
      wd_reg <= 8'h00;
      snap_reg <= '0;
    end else begin
      st_reg <= st_next;
      bit_reg <= bit_next;
      sh_reg <= sh_next;
      out_reg <= out_next;
      ptr_reg <= ptr_next;
      first_reg <= first_next;
      sda_oe_reg <= sda_oe_next;
      nack_reg <= nack_next;
      wr_reg <= wr_next;
      rd_st_reg <= rd_st_next;
      wa_reg <= wa_next;
      wd_reg <= wd_next;
      snap_reg <= snap_next;
    end
  end

  // Timekeeping, alarm and frequency output.
  wire sec_tick = osc_tick && (pre_reg == 15'(OSC_HZ - 1));
  wire time_wr = wr_reg && (wa_reg[3:0] <= `RTC_IDX_DOW);
  wire alm_on = ctrl_reg[`RTC_CT_ALMEN] && !ctrl_reg[`RTC_CT_FOUTEN];
  wire match_now = field_ok(al_reg.sec, tm_reg.sec) && field_ok(al_reg.min, tm_reg.min) &&
    field_ok(al_reg.hour, tm_reg.hour) && field_ok(al_reg.date, tm_reg.date) &&
    field_ok(al_reg.month, tm_reg.month) && field_ok(al_reg.dow, tm_reg.dow);
  wire alarm_ev = alm_on && match_now && !match_reg;

  always_comb begin
    tm_next = tm_reg;
    al_next = al_reg;
    pre_next = pre_reg;
    ctrl_next = ctrl_reg;
    frq_next = frq_reg;
    run_next = run_reg || time_wr;
    flag_next = flag_reg;
    match_next = match_now;
    pcnt_next = (pcnt_reg != 0) ? pcnt_reg - 1 : 0;
    if (osc_tick) begin
      pre_next = (pre_reg == 15'(OSC_HZ - 1)) ? 15'h0000 : pre_reg + 15'h0001;
    end
    if (sec_tick && run_reg) begin
      tm_next.sec = tm_reg.sec + 8'h01;
      if (tm_reg.sec == 8'h3B) begin
        tm_next.sec = 8'h00;
        tm_next.min = tm_reg.min + 8'h01;
        if (tm_reg.min == 8'h3B) begin
          tm_next.min = 8'h00;
          tm_next.hour = tm_reg.hour + 8'h01;
          if (tm_reg.hour == 8'h17) begin
            tm_next.hour = 8'h00;
            tm_next.dow = (tm_reg.dow == 8'h06) ? 8'h00 : tm_reg.dow + 8'h01;
            tm_next.date = tm_reg.date + 8'h01;
            if (tm_reg.date >= days_in(tm_reg.month, tm_reg.year)) begin
              tm_next.date = 8'h01;
              tm_next.month = tm_reg.month + 8'h01;
              if (tm_reg.month >= 8'h0C) begin
                tm_next.month = 8'h01;
                tm_next.year = (tm_reg.year >= 8'h63) ? 8'h00 : tm_reg.year + 8'h01;
              end
            end
          end
        end
      end
    end
    if (wr_reg) begin
      case (wa_reg[3:0])
        `RTC_IDX_SEC: tm_next.sec = wd_reg;
        `RTC_IDX_MIN: tm_next.min = wd_reg;
        `RTC_IDX_HOUR: tm_next.hour = wd_reg;
        `RTC_IDX_DATE: tm_next.date = wd_reg;
        `RTC_IDX_MONTH: tm_next.month = wd_reg;
        `RTC_IDX_YEAR: tm_next.year = wd_reg;
        `RTC_IDX_DOW: tm_next.dow = wd_reg;
        `RTC_IDX_STATUS: flag_next = flag_reg && wd_reg[`RTC_ST_ALARM];
        `RTC_IDX_CTRL: ctrl_next = wd_reg;
        `RTC_IDX_FREQ: frq_next = wd_reg[3:0];
        4'hA: al_next.sec = wd_reg;
        4'hB: al_next.min = wd_reg;
        4'hC: al_next.hour = wd_reg;
        4'hD: al_next.date = wd_reg;
        4'hE: al_next.month = wd_reg;
        default: al_next.dow = wd_reg;
      endcase
    end
    if (rd_st_reg && ctrl_reg[`RTC_CT_AUTOCLR]) begin
      flag_next = 1'b0;
    end
    if (alarm_ev) begin
      flag_next = 1'b1;
      if (ctrl_reg[`RTC_CT_PULSE]) begin
        pcnt_next = PULSE_CYC;
      end
    end
    if (!alm_on) begin
      pcnt_next = 0;
    end
    irq_oe_next = ctrl_reg[`RTC_CT_PULSE] ? (pcnt_next != 0) : (flag_next && alm_on);
    fo_oe_next = ctrl_reg[`RTC_CT_FOUTEN] && (frq_reg != 4'h0) && !pre_reg[frq_reg - 4'h1];
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tm_reg <= '0;
      al_reg <= '0;
      pre_reg <= 15'h0000;
      ctrl_reg <= `RTC_CTRL_RST;
      frq_reg <= `RTC_FREQ_RST;
      run_reg <= 1'b0;
      flag_reg <= 1'b0;
      match_reg <= 1'b0;
      pcnt_reg <= 0;
      irq_oe_reg <= 1'b0;
      fo_oe_reg <= 1'b0;
    end else begin
      tm_reg <= tm_next;
      al_reg <= al_next;
      pre_reg <= pre_next;
      ctrl_reg <= ctrl_next;
      frq_reg <= frq_next;
      run_reg <= run_next;
      flag_reg <= flag_next;
      match_reg <= match_next;
      pcnt_reg <= pcnt_next;
      irq_oe_reg <= irq_oe_next;
      fo_oe_reg <= fo_oe_next;
    end
  end

  // The open-drain data lines only ever drive low.
  always_ff @(posedge clock) begin
    osc_out <= !osc_sy[1];
    sda_o <= 1'b0;
    irq_o <= 1'b0;
    freq_out_pin_o <= 1'b0;
  end
  assign sda_oe = sda_oe_reg;
  assign irq_oe = irq_oe_reg;
  assign freq_out_pin_oe = fo_oe_reg;
  assign low_power_select = ctrl_reg[`RTC_CT_LOWPWR];
  assign alarm_flag = flag_reg;

  sequence s_pulse_armed;
    alarm_ev && ctrl_reg[`RTC_CT_PULSE];
  endsequence
  AST_PULSE_HELD: assert property (@(posedge clock) disable iff (sys_rst)
    s_pulse_armed ##1 alm_on [*8] |-> irq_oe_reg)
    else $error("pulsed interrupt dropped early");
  AST_FLAG_SET: assert property (@(posedge clock) disable iff (sys_rst)
    alarm_ev |=> flag_reg)
    else $error("alarm did not set flag");
  AST_FREQ_OUT_PIN_BLOCKS: assert property (@(posedge clock) disable iff (sys_rst)
    ctrl_reg[`RTC_CT_FOUTEN] |=> !irq_oe_reg)
    else $error("alarm fired with frequency output on");
  AST_STOPPED: assert property (@(posedge clock) disable iff (sys_rst)
    !run_reg && !wr_reg |=> $stable(tm_reg.sec))
    else $error("time moved before first write");
  AST_BACKUP_QUIET: assert property (@(posedge clock) disable iff (sys_rst)
    backup ##1 backup |-> !sda_oe_reg)
    else $error("sda driven in backup");
  AST_SNAPSHOT: assert property (@(posedge clock) disable iff (sys_rst)
    start_c && !backup |=> snap_reg == $past(tm_reg))
    else $error("snapshot not taken at start");
  AST_SEC_ROLL: assert property (@(posedge clock) disable iff (sys_rst)
    sec_tick && run_reg && !wr_reg && tm_reg.sec == 8'h3B |=> tm_reg.sec == 8'h00)
    else $error("seconds did not roll over");
  AST_LEAP: assert property (@(posedge clock) disable iff (sys_rst)
    sec_tick && run_reg && !wr_reg && tm_reg.month == 8'h02 && tm_reg.date == 8'h1C &&
    tm_reg.hour == 8'h17 && tm_reg.min == 8'h3B && tm_reg.sec == 8'h3B && tm_reg.year[1:0] == 2'h0
    |=> tm_reg.date == 8'h1D)
    else $error("leap day skipped");
  AST_AUTOCLR: assert property (@(posedge clock) disable iff (sys_rst)
    rd_st_reg && ctrl_reg[`RTC_CT_AUTOCLR] && !alarm_ev |=> !flag_reg)
    else $error("auto clear failed");
endmodule : rtc_calendar

/* File: core/rtc_cfg.svh */
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH
// Clock and time figures.
`define RTC_CLK_HZ 50000000
`define RTC_OSC_HZ 32768
`define RTC_ALARM_PULSE_MS 250
`define RTC_ALARM_PULSE_CYC (`RTC_ALARM_PULSE_MS * (`RTC_CLK_HZ / 1000))
`define RTC_I2C_ADDR 7'h50
// Register indices on the serial port.
`define RTC_IDX_SEC 4'h0
`define RTC_IDX_MIN 4'h1
`define RTC_IDX_HOUR 4'h2
`define RTC_IDX_DATE 4'h3
`define RTC_IDX_MONTH 4'h4
`define RTC_IDX_YEAR 4'h5
`define RTC_IDX_DOW 4'h6
`define RTC_IDX_STATUS 4'h7
`define RTC_IDX_CTRL 4'h8
`define RTC_IDX_FREQ 4'h9
`define RTC_IDX_ALM0 4'hA
// Field positions.
`define RTC_ST_ALARM 0
`define RTC_ST_FAIL 1
`define RTC_CT_LOWPWR 0
`define RTC_CT_AUTOCLR 1
`define RTC_CT_ALMEN 2
`define RTC_CT_PULSE 3
`define RTC_CT_FOUTEN 4
`define RTC_ALM_EN 7
// Reset values.
`define RTC_CTRL_RST 8'h00
`define RTC_FREQ_RST 4'h0
`endif

/* File: core/rtc_pkg.sv */
package rtc_pkg;
  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] date;
    logic [7:0] month;
    logic [7:0] year;
    logic [7:0] dow;
  } time_s;
  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] date;
    logic [7:0] month;
    logic [7:0] dow;
  } alarm_s;
  typedef enum logic [2:0] {
    LK_IDLE, LK_ADDR, LK_ACK_A, LK_WR, LK_ACK_W, LK_RD, LK_ACK_R
  } link_state_e;
endpackage : rtc_pkg

/* File: sim/i2c_host_model.sv */
`include "rtc_cfg.svh"
module i2c_host_model #(
  parameter int Q = 32
) (
  // Clock.
  input wire logic clock,
  // Bus lines; sda_pull high pulls the wire low.
  output logic scl,
  output logic sda_pull,
  input wire logic sda_line
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [6:0] addr = `RTC_I2C_ADDR;
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic gap();
    repeat (Q) @(posedge clock);
  endtask : gap
  // Four quarters of 32 cycles give an SCL near 390kHz.
  task automatic bit_io(input logic b, output logic seen);
    sda_pull <= ~b;
    gap();
    scl <= 1'b1;
    gap();
    seen = sda_line;
    gap();
    scl <= 1'b0;
    gap();
  endtask : bit_io
  task automatic start();
    sda_pull <= 1'b0;
    gap();
    scl <= 1'b1;
    gap();
    sda_pull <= 1'b1;
    gap();
    scl <= 1'b0;
    gap();
  endtask : start
  task automatic stop();
    sda_pull <= 1'b1;
    gap();
    scl <= 1'b1;
    gap();
    sda_pull <= 1'b0;
    gap();
  endtask : stop
  task automatic xfer(input logic [7:0] tx, input logic give_ack, output logic [7:0] rx, output logic acked);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], s);
      rx[i] = s;
    end
    bit_io(~give_ack, s);
    acked = ~s;
  endtask : xfer
  task automatic wr(input logic [3:0] idx, input logic [7:0] d[7], input int n, output logic ok);
    logic [7:0] r;
    logic a;
    start();
    xfer({addr, 1'b0}, 1'b0, r, ok);
    xfer({4'h0, idx}, 1'b0, r, a);
    ok = ok & a;
    for (int i = 0; i < n; i++) begin
      xfer(d[i], 1'b0, r, a);
      ok = ok & a;
    end
    stop();
  endtask : wr
  task automatic rd(input logic [3:0] idx, input int n, output logic [7:0] d[7], output logic ok);
    logic [7:0] r;
    logic a;
    start();
    xfer({addr, 1'b0}, 1'b0, r, ok);
    xfer({4'h0, idx}, 1'b0, r, a);
    start();
    xfer({addr, 1'b1}, 1'b0, r, a);
    ok = ok & a;
    for (int i = 0; i < n; i++) xfer(8'hFF, i < n - 1, d[i], a);
    stop();
  endtask : rd
endmodule : i2c_host_model

/* File: sim/tb_rtc_calendar.sv */
module tb_rtc_calendar;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PULSE = 50;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic osc_in = 1'b0;
  logic on_backup = 1'b0;
  logic scl, sda_pull, sda_line, sda_o, sda_oe, irq_o, irq_oe, fo_o, fo_oe, osc_out, lps, alarm_flag;
  logic ok;
  logic fo_q = 1'b0;
  logic [7:0] d [7];
  int mismatches = 0;
  int cmp_count = 0;
  int run_w = 0;
  int last_w = 0;
  int fo_rises = 0;
  int base;
  // The SDA wire has a pull-up, so a released line reads high.
  assign sda_line = (sda_oe ? sda_o : 1'b1) & ~sda_pull;
  always #10 clock = ~clock;
  rtc_calendar #(.PULSE_CYC(PULSE), .OSC_HZ(4)) i_dut (
    .clock(clock), .sys_rst(sys_rst), .osc_in(osc_in), .osc_out(osc_out), .on_backup(on_backup),
    .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .irq_o(irq_o), .irq_oe(irq_oe),
    .freq_out_pin_o(fo_o), .freq_out_pin_oe(fo_oe), .low_power_select(lps), .alarm_flag(alarm_flag)
  );
  i2c_host_model #(.Q(32)) i_host (.clock(clock), .scl(scl), .sda_pull(sda_pull), .sda_line(sda_line));
  always @(posedge clock) begin
    fo_q <= fo_oe;
    if (fo_oe === 1'b1 && fo_q === 1'b0) fo_rises <= fo_rises + 1;
    if (irq_oe === 1'b1) run_w <= run_w + 1;
    else begin
      if (run_w != 0) last_w <= run_w;
      run_w <= 0;
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic osc(input int n);
    repeat (n) begin
      @(posedge clock);
      osc_in <= 1'b1;
      repeat (5) @(posedge clock);
      osc_in <= 1'b0;
      repeat (4) @(posedge clock);
    end
    repeat (8) @(posedge clock);
  endtask : osc
  task automatic wr1(input logic [3:0] idx, input logic [7:0] v);
    d[0] = v;
    i_host.wr(idx, d, 1, ok);
    chk({7'h0, ok}, 8'h01, "write ack");
  endtask : wr1
  task automatic tally_and_finish();
    $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (115000) @(posedge clock);
    mismatches++;
    $display("BAD t=%0t watchdog expired", $time);
    tally_and_finish();
  end
  initial begin
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clock);
    chk({3'h0, irq_o, fo_o, lps, irq_oe, fo_oe}, 8'h00, "reset outputs");
    chk({7'h0, osc_out}, 8'h01, "oscillator feedback idle");
    i_host.rd(4'h7, 1, d, ok);
    chk(d[0], 8'h02, "status after reset");
    osc(8);
    i_host.rd(4'h0, 1, d, ok);
    chk(d[0], 8'h00, "seconds held");
    $display("stopped clock test done");
    // Feb 28 23:59:59 in a common year, then in a leap year.
    for (int k = 0; k < 2; k++) begin
      d = '{8'h3B, 8'h3B, 8'h17, 8'h1C, 8'h02, 8'(23 + k), 8'h06};
      i_host.wr(4'h0, d, 7, ok);
      chk({7'h0, ok}, 8'h01, "time write ack");
      osc(4);
      i_host.rd(4'h0, 7, d, ok);
      chk(d[0] | d[1] | d[2], 8'h00, "midnight");
      chk(d[3], k ? 8'h1D : 8'h01, "date");
      chk(d[4], k ? 8'h02 : 8'h03, "month");
      chk(d[5], 8'(23 + k), "year");
      chk(d[6], 8'h00, "weekday");
    end
    $display("calendar test done");
    wr1(4'hA, 8'h82);
    wr1(4'h8, 8'h04);
    osc(8);
    chk({6'h0, irq_oe, alarm_flag}, 8'h03, "single alarm");
    wr1(4'h7, 8'h00);
    chk({6'h0, irq_oe, alarm_flag}, 8'h00, "host clear");
    wr1(4'h8, 8'h0C);
    osc(240);
    repeat (PULSE) @(posedge clock);
    chk(8'(last_w), 8'(PULSE), "pulse width");
    chk({7'h0, alarm_flag}, 8'h01, "pulsed flag");
    wr1(4'h7, 8'h00);
    wr1(4'h8, 8'h0E);
    osc(240);
    chk({7'h0, alarm_flag}, 8'h01, "recurring alarm");
    i_host.rd(4'h7, 1, d, ok);
    chk(d[0], 8'h01, "status read");
    chk({7'h0, alarm_flag}, 8'h00, "auto clear");
    $display("alarm test done");
    d[0] = 8'h15;
    d[1] = 8'h01;
    i_host.wr(4'h8, d, 2, ok);
    chk({7'h0, ok}, 8'h01, "control write ack");
    chk({7'h0, lps}, 8'h01, "low power select");
    base = fo_rises;
    osc(240);
    chk({7'h0, (fo_rises - base) inside {[119:121]}}, 8'h01, "freq periods");
    chk({7'h0, alarm_flag}, 8'h00, "alarm off with freq out");
    $display("frequency test done");
    on_backup <= 1'b1;
    i_host.rd(4'h7, 1, d, ok);
    chk({7'h0, ok}, 8'h00, "no answer in backup");
    on_backup <= 1'b0;
    i_host.rd(4'h7, 1, d, ok);
    chk({7'h0, ok}, 8'h01, "answer on main supply");
    $display("backup test done");
    tally_and_finish();
  end
endmodule : tb_rtc_calendar
